// ### dcb_cfg.svh
`ifndef DCB_CFG_SVH
`define DCB_CFG_SVH

// Operation classes held in bits 1:0 of the transfer-setup base byte.
`define DCB_CLS_TRANSFER 2'b01
`define DCB_CLS_SEARCH 2'b10
`define DCB_CLS_XFER_SEARCH 2'b11

// Port A address stepping held in bits 5:4 of the configuration byte.
`define DCB_AMODE_DEC 2'b00
`define DCB_AMODE_INC 2'b01
`define DCB_AMODE_FIXED_BIT 1

// Command group codes.
`define DCB_CMD_CONTINUE 8'hd3
`define DCB_CMD_INT_MUTE 8'haf
`define DCB_CMD_INT_UNMUTE 8'hab
`define DCB_CMD_LOAD 8'hcf
`define DCB_CMD_ENABLE 8'h87
`define DCB_CMD_DISABLE 8'h83
`define DCB_CMD_FORCE_READY 8'hb3
`define DCB_CMD_INT_RESET 8'ha3
`define DCB_CMD_STATUS_REFRESH 8'hb7

// Return-from-interrupt opcode pair seen on the fetch strobe.
`define DCB_RETURN_FROM_INTERRUPT_OPCODE_PREFIX 8'hed
`define DCB_RETURN_FROM_INTERRUPT_OPCODE_CODE 8'h4d

// Status byte bit positions.
`define DCB_ST_END_OF_BLOCK 0
`define DCB_ST_DMA_ENABLED 1
`define DCB_ST_INT_ENABLED 2
`define DCB_ST_INT_PENDING 3
`define DCB_ST_IN_SERVICE 4
`define DCB_ST_FORCED_READY 5
`define DCB_ST_INT_REQUEST 6

// Host-side APB register byte offsets.
`define DCB_REG_CTRL_BYTE 8'h00
`define DCB_REG_FETCH 8'h04
`define DCB_REG_CONTROL 8'h08
`define DCB_REG_STATUS 8'h0c
`define DCB_REG_COUNT 8'h10

// Control register bits.
`define DCB_CTL_READY_BIT 0
`define DCB_CTL_ACK_BIT 1

// Reset values.
`define DCB_RST_WORD 16'h0000
`define DCB_RST_BYTE 8'h00

`endif

// ### dcb_pkg.sv
package dcb_pkg;
   // Register group that the pending associated bytes belong to.
   typedef enum logic [2:0] {
      GRP_NONE,
      GRP_TS,
      GRP_PA,
      GRP_PB,
      GRP_SC,
      GRP_IC
   } dcb_grp_t;
endpackage

// ### dcb_link_if.sv
interface dcb_link_if;
   logic ctrlValid; // One-cycle strobe: a control byte is written.
   logic [7:0] ctrlByte; // Control byte, valid with ctrlValid.
   logic fetchValid; // One-cycle strobe: the host fetched an opcode.
   logic [7:0] fetchByte; // Fetched opcode, valid with fetchValid.
   logic ackValid; // One-cycle strobe: interrupt acknowledge.
   logic intReq; // Interrupt request, active high.
   logic [7:0] status; // Device status bits.
   logic [15:0] byteCount; // Current byte counter.

   modport device (
      input ctrlValid,
      input ctrlByte,
      input fetchValid,
      input fetchByte,
      input ackValid,
      output intReq,
      output status,
      output byteCount
   );

   modport host (
      output ctrlValid,
      output ctrlByte,
      output fetchValid,
      output fetchByte,
      output ackValid,
      input intReq,
      input status,
      input byteCount
   );
endinterface

// ### dcb_device_end.sv
// Function
// RL1: Bit7 zero, class nonzero marks transfer setup.
// RL2: Bits 1:0 select transfer, search, both.
// RL3: Bit 2 picks source port, A or B.
// RL4: Host disables before reversing transfer direction.
// RL5: Bits 3,4 load start address low, high.
// RL6: Port A configuration shapes start address use.
// RL7: Bits 5,6 route bytes to block length.
// RL8: Block length low byte first, then high.
// RL9: Host programs block length before every operation.
// RL10: Count may overshoot by up to two.
// RL11: Bit7 zero, bits 2:0 100 is config.
// RL12: Bit 3 picks memory or I/O strobe.
// RL13: Bits 4,5 step; first byte unstepped.
// RL14: Preset loads source counter only, destination later.
// RL15: Host writes another byte before preset/resume.
// RL16: Preset cancels forced ready condition.
// RL17: Resume clears byte count, keeps addresses.
// RL18: New block length applies to next block.
// RL19: Mute drops request, keeps pending, in-service.
// RL20: Unmute enables interrupts, like search bit 5.
// RL21: Return-from-interrupt re-enables unless muted.
// RL22: Conditions latch while interrupts are disabled.
// RL23: Host unmutes only after full configuration.
// RL24: Following bytes fill pointed registers in order.
//
// The register addresses and the APB register port are this design's own decisions.
`include "dcb_cfg.svh"

module dcb_device_end
   import dcb_pkg::*;
(
   input wire logic ref_clk, // System clock.
   input wire logic rstn, // Synchronous reset, active low.
   dcb_link_if.device link, // Control byte link to the host end.
   input wire logic readyLine, // Ready line, active high.
   output logic memoryRequestN, // Port A memory strobe, active low.
   output logic ioRequestN, // Port A I/O strobe, active low.
   output logic [15:0] portAAddr // Port A address of the current cycle.
);

   function automatic logic [1:0] lowestSlot(input logic [3:0] mask);
      logic [1:0] idx;
      idx = 2'd3;
      if (mask[2])
      begin
         idx = 2'd2;
      end
      if (mask[1])
      begin
         idx = 2'd1;
      end
      if (mask[0])
      begin
         idx = 2'd0;
      end
      return idx;
   endfunction

   function automatic logic [15:0] stepAddr(input logic [15:0] addr,
                                            input logic [1:0] mode);
      logic [15:0] res;
      res = addr;
      if (!mode[`DCB_AMODE_FIXED_BIT])
      begin
         if (mode == `DCB_AMODE_INC)
         begin
            res = addr + 16'h0001;
         end
         else
         begin
            res = addr - 16'h0001;
         end
      end
      return res;
   endfunction

   logic [3:0] pend_reg;
   dcb_grp_t grp_reg;
   logic [1:0] opClass_reg;
   logic srcIsA_reg;
   logic [15:0] startAddr_reg;
   logic [15:0] blockLen_reg;
   logic [15:0] addrCount_reg;
   logic [15:0] byteCount_reg;
   logic aLoaded_reg;
   logic portAIsIo_reg;
   logic [1:0] portAMode_reg;
   logic dmaEnable_reg;
   logic forcedReady_reg;
   logic eob_reg;
   logic intEnable_reg;
   logic intMuted_reg;
   logic intPending_reg;
   logic inService_reg;
   logic intReq_reg;
   logic retiPrefix_reg;
   logic memReqN_reg;
   logic ioReqN_reg;
   logic [15:0] addrOut_reg;

   logic [7:0] b;
   logic isBase, isData, isCmd;
   logic tsBase, paBase, pbBase, scBase, icBase;
   logic [1:0] slot;
   logic cmdLoad, cmdContinue, cmdMute, cmdUnmute, cmdEnable;
   logic cmdForce, cmdIntReset, cmdRefresh;
   logic retiHit, portAUsed, step, lastStep, portAFixed;
   logic [15:0] curAddr, countNext;

   always_comb
   begin
      b = link.ctrlByte;
      isBase = link.ctrlValid && (pend_reg == 4'h0);
      isData = link.ctrlValid && (pend_reg != 4'h0);
      slot = lowestSlot(pend_reg);
      tsBase = isBase && !b[7] && (b[1:0] != 2'b00); // [RL1]
      paBase = isBase && !b[7] && (b[2:0] == 3'b100); // [RL11]
      pbBase = isBase && !b[7] && (b[2:0] == 3'b000);
      scBase = isBase && b[7] && (b[1:0] == 2'b00);
      icBase = isBase && b[7] && (b[1:0] == 2'b01);
      isCmd = isBase && b[7] && (b[1:0] == 2'b11);
      cmdLoad = isCmd && (b == `DCB_CMD_LOAD);
      cmdContinue = isCmd && (b == `DCB_CMD_CONTINUE);
      cmdMute = isCmd && (b == `DCB_CMD_INT_MUTE);
      cmdUnmute = (isCmd && (b == `DCB_CMD_INT_UNMUTE))
                  || (scBase && b[5]); // [RL20]
      cmdEnable = (isCmd && (b == `DCB_CMD_ENABLE)) || (scBase && b[6]);
      cmdForce = isCmd && (b == `DCB_CMD_FORCE_READY);
      cmdIntReset = isCmd && (b == `DCB_CMD_INT_RESET);
      cmdRefresh = isCmd && (b == `DCB_CMD_STATUS_REFRESH);
      retiHit = link.fetchValid && retiPrefix_reg
                && (link.fetchByte == `DCB_RETURN_FROM_INTERRUPT_OPCODE_CODE);
      // Search from Port B alone never touches Port A.
      portAUsed = srcIsA_reg || (opClass_reg != `DCB_CLS_SEARCH); // [RL3]
      portAFixed = portAMode_reg[`DCB_AMODE_FIXED_BIT];
      step = dmaEnable_reg && (readyLine || forcedReady_reg);
      curAddr = aLoaded_reg ? addrCount_reg : startAddr_reg; // [RL13]
      countNext = byteCount_reg + 16'h0001;
      // Stopping exactly at the length stays inside the allowed overshoot.
      lastStep = step && (countNext == blockLen_reg); // [RL10]
   end

   // Base byte decode and routing of associated bytes.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         pend_reg <= 4'h0;
         grp_reg <= GRP_NONE;
      end
      else if (isData)
      begin
         pend_reg <= pend_reg & ~(4'h1 << slot); // [RL24]
      end
      else if (tsBase)
      begin
         pend_reg <= b[6:3]; // [RL5] [RL7]
         grp_reg <= GRP_TS;
      end
      else if (paBase || pbBase)
      begin
         pend_reg <= {3'b000, b[6]};
         grp_reg <= paBase ? GRP_PA : GRP_PB;
      end
      else if (scBase)
      begin
         pend_reg <= {2'b00, b[4], b[3]};
         grp_reg <= GRP_SC;
      end
      else if (icBase)
      begin
         // Nested pointers inside the interrupt control byte are ignored.
         pend_reg <= {1'b0, b[4], b[3], b[2]};
         grp_reg <= GRP_IC;
      end
   end

   // Transfer setup and Port A configuration fields.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         opClass_reg <= `DCB_CLS_TRANSFER;
         srcIsA_reg <= 1'b0;
         portAIsIo_reg <= 1'b0;
         portAMode_reg <= `DCB_AMODE_INC;
         // Software must still program these; zero only keeps them defined.
         startAddr_reg <= `DCB_RST_WORD;
         blockLen_reg <= `DCB_RST_WORD; // [RL9]
      end
      else
      begin
         if (tsBase)
         begin
            opClass_reg <= b[1:0]; // [RL2]
            srcIsA_reg <= b[2]; // [RL3]
         end
         if (paBase)
         begin
            portAIsIo_reg <= b[3]; // [RL12]
            portAMode_reg <= b[5:4]; // [RL6] [RL13]
         end
         if (isData && (grp_reg == GRP_TS))
         begin
            unique case (slot)
               2'd0: startAddr_reg[7:0] <= b; // [RL5]
               2'd1: startAddr_reg[15:8] <= b;
               2'd2: blockLen_reg[7:0] <= b; // [RL8] [RL18]
               2'd3: blockLen_reg[15:8] <= b;
            endcase
         end
      end
   end

   // Port A address counter.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         addrCount_reg <= `DCB_RST_WORD;
         aLoaded_reg <= 1'b0;
      end
      else if (cmdLoad)
      begin
         // The counter copies the start address, but only a source counts as loaded now; a destination waits. [RL14]
         addrCount_reg <= startAddr_reg;
         aLoaded_reg <= srcIsA_reg;
      end
      else if (step && portAUsed)
      begin
         addrCount_reg <= stepAddr(curAddr, portAMode_reg); // [RL13]
         aLoaded_reg <= aLoaded_reg || !portAFixed; // [RL14]
      end
   end

   // Byte counter; resume keeps the address counter untouched.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         byteCount_reg <= `DCB_RST_WORD;
      end
      else if (cmdLoad || cmdContinue)
      begin
         byteCount_reg <= `DCB_RST_WORD; // [RL17]
      end
      else if (step)
      begin
         byteCount_reg <= countNext;
      end
   end

   // Enable, forced ready and end-of-block status.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         dmaEnable_reg <= 1'b0;
         forcedReady_reg <= 1'b0;
         eob_reg <= 1'b0;
      end
      else
      begin
         if (isCmd || cmdEnable)
         begin
            dmaEnable_reg <= cmdEnable;
         end
         else if (lastStep)
         begin
            dmaEnable_reg <= 1'b0;
         end
         if (cmdLoad || lastStep)
         begin
            forcedReady_reg <= 1'b0; // [RL16]
         end
         else if (cmdForce)
         begin
            forcedReady_reg <= 1'b1;
         end
         if (lastStep)
         begin
            eob_reg <= 1'b1;
         end
         else if (cmdRefresh)
         begin
            eob_reg <= 1'b0;
         end
      end
   end

   // Interrupt latches and request line.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         intEnable_reg <= 1'b0;
         intMuted_reg <= 1'b0;
         intPending_reg <= 1'b0;
         inService_reg <= 1'b0;
         intReq_reg <= 1'b0;
         retiPrefix_reg <= 1'b0;
      end
      else
      begin
         if (cmdMute || cmdIntReset)
         begin
            intEnable_reg <= 1'b0; // [RL19]
         end
         else if (cmdUnmute || (retiHit && !intMuted_reg))
         begin
            intEnable_reg <= 1'b1; // [RL20] [RL21]
         end
         if (cmdMute)
         begin
            intMuted_reg <= 1'b1;
         end
         else if (cmdUnmute || cmdIntReset)
         begin
            intMuted_reg <= 1'b0;
         end
         if (lastStep)
         begin
            intPending_reg <= 1'b1; // [RL22]
         end
         else if (cmdIntReset || link.ackValid)
         begin
            intPending_reg <= 1'b0;
         end
         if (cmdIntReset || retiHit)
         begin
            inService_reg <= 1'b0; // [RL21]
         end
         else if (link.ackValid && intReq_reg)
         begin
            inService_reg <= 1'b1;
         end
         intReq_reg <= intPending_reg && intEnable_reg && !inService_reg
                       && !cmdMute && !cmdIntReset; // [RL19]
         if (link.fetchValid)
         begin
            retiPrefix_reg <= (link.fetchByte == `DCB_RETURN_FROM_INTERRUPT_OPCODE_PREFIX);
         end
      end
   end

   // Port A cycle strobes.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         memReqN_reg <= 1'b1;
         ioReqN_reg <= 1'b1;
         addrOut_reg <= `DCB_RST_WORD;
      end
      else
      begin
         memReqN_reg <= !(step && portAUsed && !portAIsIo_reg); // [RL12]
         ioReqN_reg <= !(step && portAUsed && portAIsIo_reg);
         if (step && portAUsed)
         begin
            addrOut_reg <= curAddr;
         end
      end
   end

   assign memoryRequestN = memReqN_reg;
   assign ioRequestN = ioReqN_reg;
   assign portAAddr = addrOut_reg;
   assign link.intReq = intReq_reg;
   assign link.byteCount = byteCount_reg;
   assign link.status = {1'b0, intReq_reg, forcedReady_reg, inService_reg,
                         intPending_reg, intEnable_reg, dmaEnable_reg,
                         eob_reg};

endmodule

// ### dcb_host_end.sv
`include "dcb_cfg.svh"

module dcb_host_end
   import dcb_pkg::*;
(
   input wire logic ref_clk, // System clock.
   input wire logic rstn, // Synchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB write, high for write.
   input wire logic [7:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   output logic readyOut, // Ready level for the device.
   dcb_link_if.host link // Control byte link to the device end.
);

   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic ctrlValid_reg;
   logic [7:0] ctrlByte_reg;
   logic fetchValid_reg;
   logic [7:0] fetchByte_reg;
   logic ackValid_reg;
   logic ready_reg;
   logic setup, wrDone, mapped;

   always_comb
   begin
      setup = psel && !penable;
      wrDone = psel && penable && pready_reg && pwrite;
      mapped = (paddr == `DCB_REG_CTRL_BYTE) || (paddr == `DCB_REG_FETCH)
               || (paddr == `DCB_REG_CONTROL) || (paddr == `DCB_REG_STATUS)
               || (paddr == `DCB_REG_COUNT);
   end

   // Ready rises for the first access cycle, so every transfer takes two.
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end
      else
      begin
         pready_reg <= setup;
         pslverr_reg <= setup && !mapped;
         if (setup && !pwrite)
         begin
            unique case (paddr)
               `DCB_REG_CTRL_BYTE: prdata_reg <= {24'h000000, ctrlByte_reg};
               `DCB_REG_FETCH: prdata_reg <= {24'h000000, fetchByte_reg};
               `DCB_REG_CONTROL: prdata_reg <= {31'h00000000, ready_reg};
               `DCB_REG_STATUS: prdata_reg <= {24'h000000, link.status};
               `DCB_REG_COUNT: prdata_reg <= {16'h0000, link.byteCount};
               default: prdata_reg <= 32'h00000000;
            endcase
         end
         else if (setup)
         begin
            prdata_reg <= 32'h00000000;
         end
      end
   end

   // Each write sends one byte; the order and timing of the bytes stay
   // with software, which must keep the programming sequence. [RL4] [RL9]
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         ctrlValid_reg <= 1'b0;
         ctrlByte_reg <= `DCB_RST_BYTE;
      end
      else
      begin
         ctrlValid_reg <= wrDone && (paddr == `DCB_REG_CTRL_BYTE); // [RL15]
         if (wrDone && (paddr == `DCB_REG_CTRL_BYTE))
         begin
            ctrlByte_reg <= pwdata[7:0]; // [RL23]
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         fetchValid_reg <= 1'b0;
         fetchByte_reg <= `DCB_RST_BYTE;
      end
      else
      begin
         fetchValid_reg <= wrDone && (paddr == `DCB_REG_FETCH); // [RL21]
         if (wrDone && (paddr == `DCB_REG_FETCH))
         begin
            fetchByte_reg <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         ready_reg <= 1'b0;
         ackValid_reg <= 1'b0;
      end
      else
      begin
         ackValid_reg <= wrDone && (paddr == `DCB_REG_CONTROL)
                         && pwdata[`DCB_CTL_ACK_BIT];
         if (wrDone && (paddr == `DCB_REG_CONTROL))
         begin
            ready_reg <= pwdata[`DCB_CTL_READY_BIT];
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign readyOut = ready_reg;
   assign link.ctrlValid = ctrlValid_reg;
   assign link.ctrlByte = ctrlByte_reg;
   assign link.fetchValid = fetchValid_reg;
   assign link.fetchByte = fetchByte_reg;
   assign link.ackValid = ackValid_reg;

endmodule

// ### dcb_link_assertions.sv
`include "dcb_cfg.svh"

module dcb_link_assertions (
   input wire logic ref_clk, // System clock.
   input wire logic rstn, // Synchronous reset, active low.
   input wire logic ctrlValid, // Control byte strobe.
   input wire logic [7:0] ctrlByte, // Control byte.
   input wire logic fetchValid, // Opcode fetch strobe.
   input wire logic [7:0] fetchByte, // Fetched opcode.
   input wire logic ackValid, // Interrupt acknowledge strobe.
   input wire logic intReq, // Interrupt request.
   input wire logic [7:0] status, // Device status bits.
   input wire logic [15:0] byteCount // Byte counter.
);
   logic sawPrefix;
   // Command codes are only trusted as commands because the bench never
   // sends such values as associated data bytes.
   wire isCmd = ctrlValid && ctrlByte[7] && ctrlByte[1:0] == 2'b11;

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         sawPrefix <= 1'b0;
      else if (fetchValid)
         sawPrefix <= fetchByte == `DCB_RETURN_FROM_INTERRUPT_OPCODE_PREFIX;
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   chk_ctrl_pulse: assert property (ctrlValid |=> !ctrlValid)
      else $error("control strobe longer than one cycle");
   chk_cmd_disables: assert property (
      isCmd && ctrlByte != `DCB_CMD_ENABLE |-> ##[1:2] !status[1])
      else $error("command did not disable the engine");
   chk_load_clears: assert property (
      ctrlValid && ctrlByte == `DCB_CMD_LOAD
      |-> ##[1:2] byteCount == 16'h0000 && !status[5])
      else $error("preset left count or forced ready");
   chk_resume_zero: assert property (
      ctrlValid && ctrlByte == `DCB_CMD_CONTINUE
      |-> ##[1:2] byteCount == 16'h0000)
      else $error("resume did not clear the count");
   chk_mute_release: assert property (
      ctrlValid && ctrlByte == `DCB_CMD_INT_MUTE
      |-> ##[1:3] !intReq && !status[2])
      else $error("mute did not release the request");
   chk_mute_keeps: assert property (
      ctrlValid && ctrlByte == `DCB_CMD_INT_MUTE && status[3]
      |-> ##2 status[3])
      else $error("mute cleared the pending latch");
   chk_unmute_on: assert property (
      ctrlValid && ctrlByte == `DCB_CMD_INT_UNMUTE |-> ##[1:2] status[2])
      else $error("unmute did not enable interrupts");
   chk_return_from_interrupt_opcode_release: assert property (
      fetchValid && fetchByte == `DCB_RETURN_FROM_INTERRUPT_OPCODE_CODE && sawPrefix
      |-> ##[1:2] !status[4])
      else $error("return opcode left in service set");
   chk_latch_quiet: assert property (
      (status[3] && !status[2]) [*3] |-> !intReq)
      else $error("request raised while interrupts disabled");
   chk_count_step: assert property (
      $changed(byteCount) && byteCount != 16'h0000
      |-> byteCount == $past(byteCount) + 16'h0001)
      else $error("byte counter jumped");
   chk_ack_service: assert property (
      ackValid && intReq |=> status[4])
      else $error("acknowledge did not set in service");
endmodule

// ### dma_control_byte_decoder_tb_top.sv
`include "dcb_cfg.svh"

module dma_control_byte_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic readyOut;
   logic memoryRequestN;
   logic ioRequestN;
   logic [15:0] portAAddr;
   logic [31:0] memLows = 32'h0;
   logic [31:0] ioLows = 32'h0;
   int num_errors = 0;
   int checks = 0;

   dcb_link_if link ();
   dcb_host_end i_dcb_host_end (
      .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .readyOut(readyOut),
      .link(link.host));
   dcb_device_end i_dcb_device_end (
      .ref_clk(ref_clk), .rstn(rstn), .link(link.device),
      .readyLine(readyOut), .memoryRequestN(memoryRequestN),
      .ioRequestN(ioRequestN), .portAAddr(portAAddr));
   dcb_link_assertions i_dcb_link_assertions (
      .ref_clk(ref_clk), .rstn(rstn), .ctrlValid(link.ctrlValid),
      .ctrlByte(link.ctrlByte), .fetchValid(link.fetchValid),
      .fetchByte(link.fetchByte), .ackValid(link.ackValid),
      .intReq(link.intReq), .status(link.status),
      .byteCount(link.byteCount));

   initial
   begin
      forever #25 ref_clk = ~ref_clk;
   end

   // Strobe cycles are counted so that each engine step on Port A is seen once.
   always @(posedge ref_clk)
   begin
      if (memoryRequestN === 1'b0)
         memLows <= memLows + 32'h1;
      if (ioRequestN === 1'b0)
         ioLows <= ioLows + 32'h1;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      q = prdata;
      err = pslverr;
      if (pready !== 1'b1)
         num_errors++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask

   // The extra cycles let the link pulse land before anyone looks.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic send(input logic [7:0] b);
      wr(`DCB_REG_CTRL_BYTE, {24'h0, b});
   endtask

   task automatic wait_eob();
      logic [31:0] q;
      int n;
      n = 0;
      do
      begin
         rd(`DCB_REG_STATUS, q);
         n++;
      end
      while (q[`DCB_ST_END_OF_BLOCK] !== 1'b1 && n < 40);
      check(q & 32'h3, 32'h1);
   endtask

   task automatic run_block(input logic [7:0] base, input logic [7:0] cfg,
                            input logic [31:0] mem, input logic [31:0] io,
                            input logic [15:0] last);
      logic [31:0] q;
      logic [31:0] memBase;
      logic [31:0] ioBase;
      send(`DCB_CMD_DISABLE);
      send(`DCB_CMD_STATUS_REFRESH);
      send(base);
      send(8'h34);
      send(8'h12);
      send(8'h03);
      send(8'h00);
      send(cfg);
      send(`DCB_CMD_LOAD);
      wr(`DCB_REG_CONTROL, 32'h1);
      // The strobe counters have one driver; a block is judged by its delta.
      memBase = memLows;
      ioBase = ioLows;
      send(`DCB_CMD_ENABLE);
      wait_eob();
      rd(`DCB_REG_COUNT, q);
      check(q, 32'h3);
      check(memLows - memBase, mem);
      check(ioLows - ioBase, io);
      if (mem != 0 || io != 0)
         check({16'h0, portAAddr}, {16'h0, last});
   endtask

   task automatic test_reset();
      logic [31:0] q;
      logic e;
      rd(`DCB_REG_STATUS, q);
      check(q, 32'h0);
      check({30'h0, memoryRequestN, ioRequestN}, 32'h3);
      apb(1'b0, 8'h20, 32'h0, q, e);
      check({q[30:0], e}, 32'h1);
   endtask

   task automatic test_stepping();
      run_block(8'h7a, 8'h14, 32'h0, 32'h0, 16'h0);
      run_block(8'h7b, 8'h14, 32'h3, 32'h0, 16'h1236);
      run_block(8'h7f, 8'h2c, 32'h0, 32'h3, 16'h1234);
      run_block(8'h7d, 8'h04, 32'h3, 32'h0, 16'h1232);
      run_block(8'h7d, 8'h14, 32'h3, 32'h0, 16'h1236);
   endtask

   task automatic test_resume();
      logic [31:0] q;
      send(`DCB_CMD_STATUS_REFRESH);
      send(8'h65);
      send(8'h02);
      send(8'h00);
      send(`DCB_CMD_CONTINUE);
      rd(`DCB_REG_COUNT, q);
      check(q, 32'h0);
      send(`DCB_CMD_ENABLE);
      wait_eob();
      rd(`DCB_REG_COUNT, q);
      check(q, 32'h2);
      check({16'h0, portAAddr}, 32'h1238);
   endtask

   task automatic test_force();
      logic [31:0] q;
      wr(`DCB_REG_CONTROL, 32'h0);
      send(`DCB_CMD_FORCE_READY);
      rd(`DCB_REG_STATUS, q);
      check(q & 32'h20, 32'h20);
      send(`DCB_CMD_LOAD);
      rd(`DCB_REG_STATUS, q);
      check(q & 32'h20, 32'h0);
   endtask

   task automatic return_from_interrupt_opcode();
      wr(`DCB_REG_FETCH, {24'h0, `DCB_RETURN_FROM_INTERRUPT_OPCODE_PREFIX});
      wr(`DCB_REG_FETCH, {24'h0, `DCB_RETURN_FROM_INTERRUPT_OPCODE_CODE});
   endtask

   task automatic test_interrupts();
      logic [31:0] q;
      rd(`DCB_REG_STATUS, q);
      check(q & 32'h1c, 32'h08);
      check({31'h0, link.intReq}, 32'h0);
      send(`DCB_CMD_INT_UNMUTE);
      check({31'h0, link.intReq}, 32'h1);
      send(`DCB_CMD_INT_MUTE);
      rd(`DCB_REG_STATUS, q);
      check(q & 32'h1c, 32'h08);
      check({31'h0, link.intReq}, 32'h0);
      send(`DCB_CMD_INT_UNMUTE);
      wr(`DCB_REG_CONTROL, 32'h2);
      rd(`DCB_REG_STATUS, q);
      check(q & 32'h1c, 32'h14);
      return_from_interrupt_opcode();
      rd(`DCB_REG_STATUS, q);
      check(q & 32'h1c, 32'h04);
      send(`DCB_CMD_INT_MUTE);
      return_from_interrupt_opcode();
      rd(`DCB_REG_STATUS, q);
      check(q & 32'h1c, 32'h00);
      // A full reset leaves interrupts off but not muted, so the return
      // opcode alone must turn them back on.
      send(`DCB_CMD_INT_RESET);
      return_from_interrupt_opcode();
      rd(`DCB_REG_STATUS, q);
      check(q & 32'h1c, 32'h04);
      send(`DCB_CMD_INT_MUTE);
      send(8'ha0);
      rd(`DCB_REG_STATUS, q);
      check(q & 32'h1c, 32'h04);
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // The whole sequence needs under a thousand cycles; this leaves ample room.
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      give_verdict();
   end

   initial
   begin
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      test_reset();
      test_stepping();
      test_resume();
      test_force();
      test_interrupts();
      give_verdict();
   end
endmodule
